/* File: hw/fpe_pkg.sv */
// Package of constants, types and helpers for the flash program and erase control
//
// Overview of operation
// R01: Programming only clears bits; new data is ANDed with the stored byte.
// R02: Erase sets every byte of one whole 1024-byte page to 0xFF.
// R03: Busy flag stays one while any write or erase runs.
// R04: Fetches needing the flash array stall until the operation ends.
// R05: Interrupts arising while stalled on flash stay deferred until completion.
// R06: Redirect bit one sends external-move writes to flash, else to data RAM.
// R07: Redirect bit is cleared only by software, never by hardware.
// R08: External-move reads always go to external data RAM.
// R09: Code-read instruction reads flash contents for constants and data.
// R10: Bank select picks the upper bank shown at 0x08000 to 0x0FFFF.
// R11: Targets above 0x07FFF follow bank select; lower ones hit bank zero.
// R12: Small variant software keeps bank select at binary 01.
// R13: Software avoids writing the reserved page starting at 0x1FC00.
// R14: Hardware times each erase (12 ms) and byte write (50 us) itself.
// R15: Scratchpad enable maps 0x00-0xFF code reads and writes to scratchpad sectors.
// R16: Instruction fetches from the scratchpad are refused.
// R17: Scratch sectors erase singly; erase at 0x0400 clears both.
// R18: Erase needs unlock, redirect and erase-enable set plus a write in the page.
// R19: Software follows the recommended erase sequence with interrupts off.
// R20: Software keeps interrupts off while the redirect bit is set.
// R21: Writes with unlock clear start no flash operation.
// R22: Busy flag clears in the cycle the timed operation completes.
package fpe_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int WRITE_TIME_US = 50;
    localparam int ERASE_TIME_MS = 12;
    localparam int WRITE_CYCLES = WRITE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int ERASE_CYCLES = ERASE_TIME_MS * (CLK_HZ / 1_000);
    localparam int TIMER_W = 20;

    localparam logic [3:0] OFS_STORE_CTRL = 4'h0;
    localparam logic [3:0] OFS_BANK_SEL = 4'h4;
    localparam logic [3:0] OFS_SCALE = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;

    localparam int BIT_REDIRECT = 0;
    localparam int BIT_ERASE_EN = 1;
    localparam int BIT_SCRATCH = 2;
    localparam int BIT_UNLOCK = 0;
    localparam int BIT_BUSY = 0;
    localparam int BANK_LSB = 4;

    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [1:0] BANK_RESET = 2'h1;
    localparam logic UNLOCK_RESET = 1'b0;

    localparam logic [15:0] UPPER_BASE = 16'h8000;
    localparam logic [15:0] SCRATCH_TOP = 16'h00FF;
    localparam logic [15:0] SCRATCH_BOTH = 16'h0400;
    localparam int PAGE_BITS = 10;
    localparam int SPAGE_BITS = 7;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic scratch;
        logic [16:0] addr;
    } fpe_phys_s;

    typedef enum {S_IDLE, S_READ, S_PROG, S_ERASE} fpe_state_e;

    // Logical 16-bit address to array address under bank and scratch settings
    function automatic fpe_phys_s fpe_map(input logic [15:0] a, input logic [1:0] bank,
                                          input logic scratchpad_access_enable);
        fpe_phys_s p;
        p.scratch = scratchpad_access_enable && (a <= SCRATCH_TOP);
        if (p.scratch) begin
            p.addr = {9'h000, a[7:0]};
        end else if (a >= UPPER_BASE) begin
            p.addr = {bank, a[14:0]};
        end else begin
            p.addr = {2'h0, a[14:0]};
        end
        return p;
    endfunction : fpe_map
endpackage : fpe_pkg

/* File: hw/fpe_timer.sv */
// Down-counter that times one flash operation and pulses done at its end
`timescale 1ns/10ps
`default_nettype none
module fpe_timer #(
    parameter int CW = 20
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [CW-1:0] cycles,
    output logic done
);
    logic [CW-1:0] cnt_reg;
    logic run_reg;

    assign done = run_reg && (cnt_reg == CW'(1));

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
        end else if (start) begin
            cnt_reg <= cycles;
            run_reg <= 1'b1;
        end else if (done) begin
            run_reg <= 1'b0;
        end else if (run_reg) begin
            cnt_reg <= cnt_reg - CW'(1);
        end
    end
endmodule : fpe_timer
`default_nettype wire

/* File: hw/fpe_ctrl.sv */
// Flash program and erase sequencer with register file and core access ports
`timescale 1ns/10ps
`default_nettype none
module fpe_ctrl
    import fpe_pkg::*;
#(
    parameter int ERASE_CNT = fpe_pkg::ERASE_CYCLES,
    parameter int WRITE_CNT = fpe_pkg::WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    // AXI4-Lite register slave
    input wire logic [3:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [3:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // External-move port from the core
    input wire logic xm_req,
    input wire logic xm_we,
    input wire logic [15:0] xm_addr,
    input wire logic [7:0] xm_wdata,
    output logic xm_stall,
    output logic external_data_ram_req,
    output logic external_data_ram_we,
    output logic [15:0] external_data_ram_addr,
    output logic [7:0] external_data_ram_wdata,
    // Code-read and fetch port from the core
    input wire logic rd_req,
    input wire logic rd_fetch,
    input wire logic [15:0] rd_addr,
    output logic rd_stall,
    output logic rd_fault,
    output logic rd_valid,
    output logic [7:0] rd_rdata,
    output logic irq_defer,
    output logic flash_busy_flag,
    // Flash array macro
    output logic fl_rd_en,
    output fpe_pkg::fpe_phys_s fl_addr,
    input wire logic [7:0] fl_rdata,
    output logic fl_prog,
    output logic fl_erase,
    output logic fl_erase_both,
    output logic [7:0] fl_wdata
);
    import fpe_pkg::*;

    logic [2:0] ctrl_reg;
    logic [1:0] bank_reg;
    logic unlock_reg;
    fpe_state_e state_reg;
    fpe_phys_s op_addr_reg;
    logic op_both_reg;
    logic [7:0] op_data_reg;
    logic [7:0] old_reg;
    logic prog_first_reg;
    logic [7:0] old_byte;
    logic rd_valid_reg;
    logic external_data_ram_req_reg;
    logic external_data_ram_we_reg;
    logic [15:0] external_data_ram_addr_reg;
    logic [7:0] external_data_ram_wdata_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [3:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic redirect;
    logic erase_en;
    logic scratchpad_access_enable;
    logic busy;
    logic wr_fire;
    logic start_prog;
    logic start_erase;
    logic tmr_start;
    logic tmr_done;
    logic [TIMER_W-1:0] tmr_cycles;
    logic rd_go;
    logic xm_idle_go;
    fpe_phys_s xm_phys;
    fpe_phys_s rd_phys;

    assign redirect = ctrl_reg[BIT_REDIRECT];
    assign erase_en = ctrl_reg[BIT_ERASE_EN];
    assign scratchpad_access_enable = ctrl_reg[BIT_SCRATCH];
    assign busy = (state_reg != S_IDLE);
    assign flash_busy_flag = busy; // R03 R22

    // Register bus: write side
    assign s_awready = !aw_held_reg && !bvalid_reg;
    assign s_wready = !w_held_reg && !bvalid_reg;
    assign s_bvalid = bvalid_reg;
    assign s_bresp = bresp_reg;
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_wdata;
                w_strb_reg <= s_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= (aw_addr_reg == OFS_STORE_CTRL || aw_addr_reg == OFS_BANK_SEL ||
                              aw_addr_reg == OFS_SCALE || aw_addr_reg == OFS_STATUS)
                             ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && s_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Control bits change only by software writes
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg <= CTRL_RESET;
            bank_reg <= BANK_RESET;
            unlock_reg <= UNLOCK_RESET;
        end else if (wr_fire && w_strb_reg[0]) begin
            unique case (aw_addr_reg)
                OFS_STORE_CTRL: ctrl_reg <= w_data_reg[2:0]; // R07
                OFS_BANK_SEL: bank_reg <= w_data_reg[BANK_LSB +: 2];
                OFS_SCALE: unlock_reg <= w_data_reg[BIT_UNLOCK];
                default: ;
            endcase
        end
    end

    // Register bus: read side
    assign s_arready = !rvalid_reg;
    assign s_rvalid = rvalid_reg;
    assign s_rdata = rdata_reg;
    assign s_rresp = rresp_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
            unique case (s_araddr)
                OFS_STORE_CTRL: rdata_reg <= {29'h0, ctrl_reg};
                OFS_BANK_SEL: rdata_reg <= {26'h0, bank_reg, 4'h0};
                OFS_SCALE: rdata_reg <= {31'h0, unlock_reg};
                OFS_STATUS: rdata_reg <= {31'h0, busy};
                default: rresp_reg <= RESP_SLVERR;
            endcase
        end else if (rvalid_reg && s_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // External-move routing
    assign xm_stall = busy;
    assign xm_idle_go = xm_req && !busy;
    assign xm_phys = fpe_map(xm_addr, bank_reg, scratchpad_access_enable); // R10 R11 R15
    assign start_prog = xm_idle_go && xm_we && redirect && unlock_reg && !erase_en; // R21
    assign start_erase = xm_idle_go && xm_we && redirect && unlock_reg && erase_en; // R18

    always_ff @(posedge clk) begin
        if (srst) begin
            external_data_ram_req_reg <= 1'b0;
            external_data_ram_we_reg <= 1'b0;
            external_data_ram_addr_reg <= '0;
            external_data_ram_wdata_reg <= '0;
        end else begin
            external_data_ram_req_reg <= xm_idle_go && !(xm_we && redirect); // R06 R08
            external_data_ram_we_reg <= xm_idle_go && xm_we && !redirect; // R06
            if (xm_idle_go) begin
                external_data_ram_addr_reg <= xm_addr;
                external_data_ram_wdata_reg <= xm_wdata;
            end
        end
    end

    assign external_data_ram_req = external_data_ram_req_reg;
    assign external_data_ram_we = external_data_ram_we_reg;
    assign external_data_ram_addr = external_data_ram_addr_reg;
    assign external_data_ram_wdata = external_data_ram_wdata_reg;

    // Operation sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= S_IDLE;
            op_addr_reg <= '0;
            op_both_reg <= 1'b0;
            op_data_reg <= '0;
            old_reg <= ERASED_BYTE;
            prog_first_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                S_IDLE: begin
                    if (start_prog) begin
                        state_reg <= S_READ;
                        op_addr_reg <= xm_phys;
                        op_data_reg <= xm_wdata;
                    end else if (start_erase) begin
                        state_reg <= S_ERASE;
                        op_both_reg <= scratchpad_access_enable && (xm_addr == SCRATCH_BOTH); // R17
                        op_addr_reg <= xm_phys;
                        if (scratchpad_access_enable && (xm_addr == SCRATCH_BOTH)) begin
                            op_addr_reg <= '{scratch: 1'b1, addr: '0};
                        end
                    end
                end
                S_READ: begin
                    state_reg <= S_PROG;
                end
                S_PROG: begin
                    if (tmr_done) begin
                        state_reg <= S_IDLE; // R22
                    end
                end
                S_ERASE: begin
                    if (tmr_done) begin
                        state_reg <= S_IDLE; // R22
                        op_both_reg <= 1'b0;
                    end
                end
            endcase
            // Array data lands one cycle after the read strobe
            prog_first_reg <= (state_reg == S_READ);
            if (prog_first_reg) begin
                old_reg <= fl_rdata;
            end
        end
    end

    assign tmr_start = (state_reg == S_READ) || start_erase; // R14
    assign tmr_cycles = start_erase ? TIMER_W'(ERASE_CNT) : TIMER_W'(WRITE_CNT);

    fpe_timer #(.CW(TIMER_W)) i_fpe_timer (
        .clk(clk),
        .srst(srst),
        .start(tmr_start),
        .cycles(tmr_cycles),
        .done(tmr_done)
    );

    // Array drive
    assign rd_phys = fpe_map(rd_addr, bank_reg, scratchpad_access_enable); // R09 R15
    assign rd_fault = rd_req && rd_fetch && rd_phys.scratch; // R16
    assign rd_stall = rd_req && busy; // R04
    assign irq_defer = rd_stall; // R05
    assign rd_go = rd_req && !busy && !rd_fault;
    assign fl_prog = (state_reg == S_PROG);
    assign fl_erase = (state_reg == S_ERASE);
    assign fl_erase_both = fl_erase && op_both_reg; // R17
    // First program cycle uses the byte still on the array bus
    assign old_byte = prog_first_reg ? fl_rdata : old_reg;
    assign fl_wdata = op_data_reg & old_byte; // R01

    always_comb begin
        fl_rd_en = rd_go || (state_reg == S_READ);
        fl_addr = rd_phys;
        if (busy) begin
            fl_addr = op_addr_reg;
        end
        if (state_reg == S_ERASE) begin
            if (op_addr_reg.scratch) begin
                fl_addr.addr[SPAGE_BITS-1:0] = '0; // R17
            end else begin
                fl_addr.addr[PAGE_BITS-1:0] = '0; // R02
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_go;
        end
    end

    assign rd_valid = rd_valid_reg;
    assign rd_rdata = fl_rdata;

    // Checks
    property p_busy_op;
        @(posedge clk) disable iff (srst) (fl_prog || fl_erase) |-> flash_busy_flag;
    endproperty
    a_busy_op: assert property (p_busy_op) else $error("op without busy"); // R03

    property p_prog_clears;
        @(posedge clk) disable iff (srst)
            (fl_prog && prog_first_reg) |-> ((fl_wdata & ~fl_rdata) == 8'h00);
    endproperty
    a_prog_clears: assert property (p_prog_clears) else $error("program sets a bit"); // R01

    property p_page_align;
        @(posedge clk) disable iff (srst)
            (fl_erase && !fl_addr.scratch) |-> (fl_addr.addr[9:0] == 10'h000);
    endproperty
    a_page_align: assert property (p_page_align) else $error("erase not page aligned"); // R02

    property p_fetch_stall;
        @(posedge clk) disable iff (srst)
            (rd_req && busy) |-> (rd_stall && !rd_valid_reg ##1 !rd_valid);
    endproperty
    a_fetch_stall: assert property (p_fetch_stall) else $error("fetch not stalled"); // R04

    property p_redirect_write;
        @(posedge clk) disable iff (srst)
            (xm_req && xm_we && !busy && redirect) |=> !external_data_ram_we && !external_data_ram_req;
    endproperty
    a_redirect_write: assert property (p_redirect_write) else $error("write reached RAM"); // R06

    property p_redirect_holds;
        @(posedge clk) disable iff (srst)
            (redirect && !(wr_fire && aw_addr_reg == OFS_STORE_CTRL)) |=> redirect;
    endproperty
    a_redirect_holds: assert property (p_redirect_holds) else $error("redirect dropped"); // R07

    property p_read_ram;
        @(posedge clk) disable iff (srst) (xm_req && !xm_we && !busy) |=> external_data_ram_req && !external_data_ram_we;
    endproperty
    a_read_ram: assert property (p_read_ram) else $error("read not to RAM"); // R08

    property p_locked;
        @(posedge clk) disable iff (srst)
            (!busy && !unlock_reg) |=> (state_reg == S_IDLE);
    endproperty
    a_locked: assert property (p_locked) else $error("op while locked"); // R21

    property p_bank_steer;
        @(posedge clk) disable iff (srst)
            (start_prog && xm_addr[15] && !scratchpad_access_enable) |=> (op_addr_reg.addr[16:15] == $past(bank_reg));
    endproperty
    a_bank_steer: assert property (p_bank_steer) else $error("bank not steered"); // R11

    property p_no_scratch_exec;
        @(posedge clk) disable iff (srst) (rd_req && rd_fetch && rd_phys.scratch) |-> !rd_go;
    endproperty
    a_no_scratch_exec: assert property (p_no_scratch_exec) else $error("scratch exec"); // R16

    property p_both;
        @(posedge clk) disable iff (srst)
            (start_erase && scratchpad_access_enable && xm_addr == SCRATCH_BOTH) |=> fl_erase_both [*2];
    endproperty
    a_both: assert property (p_both) else $error("both sectors not erased"); // R17
endmodule : fpe_ctrl
`default_nettype wire

/* File: test/fpe_flash_model.sv */
// Behavioural flash array answering the sequencer's read, program and erase strobes
`timescale 1ns/10ps
`default_nettype none
module fpe_flash_model
    import fpe_pkg::*;
(
    input wire logic clk,
    input wire logic fl_rd_en,
    input wire fpe_pkg::fpe_phys_s fl_addr,
    output logic [7:0] fl_rdata,
    input wire logic fl_prog,
    input wire logic fl_erase,
    input wire logic fl_erase_both,
    input wire logic [7:0] fl_wdata
);
    logic [7:0] mem [int];
    logic [7:0] rd_q = 8'h00;
    logic prog_d = 1'b0;
    logic erase_d = 1'b0;
    int key;
    int span;
    int base;

    assign fl_rdata = rd_q;
    always_comb key = int'({fl_addr.scratch, fl_addr.addr});

    always @(posedge clk) begin
        prog_d <= fl_prog;
        erase_d <= fl_erase;
        // Idle data bus toggles so a stale byte is never mistaken for a read
        rd_q <= fl_rd_en ? (mem.exists(key) ? mem[key] : ERASED_BYTE) : ~rd_q;
        // Stores exactly what it is handed; masking old bits is the sequencer's job
        if (fl_prog && !prog_d) begin
            mem[key] = fl_wdata;
        end
        if (fl_erase && !erase_d) begin
            span = fl_erase_both ? 256 : (fl_addr.scratch ? 128 : 1024);
            base = fl_erase_both ? 32'h20000 : (key & ~(span - 1));
            for (int i = 0; i < span; i++) begin
                mem[base + i] = ERASED_BYTE;
            end
        end
    end
endmodule : fpe_flash_model
`default_nettype wire

/* File: test/tb_flash_program_erase_control.sv */
// Self-checking bench for the flash program and erase sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_flash_program_erase_control;
    import fpe_pkg::*;
    localparam int EC = 20;
    localparam int WC = 10;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] s_awaddr, s_araddr, s_wstrb;
    logic [31:0] s_wdata, s_rdata;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, s_arvalid, s_arready;
    logic s_rvalid, s_rready, xm_req, xm_we, xm_stall, external_data_ram_req, external_data_ram_we, rd_req, rd_fetch;
    logic rd_stall, rd_fault, rd_valid, irq_defer, flash_busy_flag, fl_rd_en, fl_prog;
    logic fl_erase, fl_erase_both;
    logic [1:0] s_bresp, s_rresp;
    logic [15:0] xm_addr, external_data_ram_addr, rd_addr;
    logic [7:0] xm_wdata, external_data_ram_wdata, rd_rdata, fl_rdata, fl_wdata;
    fpe_phys_s fl_addr;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int external_data_ram_cnt = 0;
    logic [24:0] external_data_ram_last;
    logic [31:0] rnd = 32'h9F99;

    fpe_ctrl #(.ERASE_CNT(EC), .WRITE_CNT(WC)) i_fpe_ctrl (
        .clk, .srst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
        .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
        .s_rdata, .s_rresp, .s_rvalid, .s_rready, .xm_req, .xm_we, .xm_addr, .xm_wdata,
        .xm_stall, .external_data_ram_req, .external_data_ram_we, .external_data_ram_addr, .external_data_ram_wdata, .rd_req, .rd_fetch,
        .rd_addr, .rd_stall, .rd_fault, .rd_valid, .rd_rdata, .irq_defer, .flash_busy_flag,
        .fl_rd_en, .fl_addr, .fl_rdata, .fl_prog, .fl_erase, .fl_erase_both, .fl_wdata
    );
    fpe_flash_model i_fpe_flash_model (
        .clk, .fl_rd_en, .fl_addr, .fl_rdata, .fl_prog, .fl_erase, .fl_erase_both, .fl_wdata
    );

    always #10 clk = ~clk;

    always @(posedge clk) begin
        cyc++;
        if (external_data_ram_req === 1'b1) begin
            external_data_ram_cnt++;
            external_data_ram_last <= {external_data_ram_we, external_data_ram_addr, external_data_ram_wdata};
        end
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic [7:0] prog_exp(input logic [7:0] old, input logic [7:0] nw);
        return old & nw;
    endfunction : prog_exp

    task automatic print_verdict();
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (s_awvalid && s_awready) begin
                aw_ok = 1'b1;
                s_awvalid <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_ok = 1'b1;
                s_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (s_bvalid !== 1'b1);
        r = s_bresp;
        s_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge clk); while (s_arready !== 1'b1);
        s_arvalid <= 1'b0;
        do @(posedge clk); while (s_rvalid !== 1'b1);
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
    endtask : axi_rd

    // Core move; during a flash operation a fetch is probed to see it stall
    task automatic xm(input logic we, input logic [15:0] a, input logic [7:0] d, output int n);
        n = 0;
        @(posedge clk);
        xm_req <= 1'b1;
        xm_we <= we;
        xm_addr <= a;
        xm_wdata <= d;
        @(posedge clk);
        xm_req <= 1'b0;
        #1;
        while (flash_busy_flag === 1'b1) begin
            n++;
            rd_req <= (n == 2);
            rd_fetch <= 1'b1;
            @(posedge clk);
            #1;
            if (n == 2) `CHK({rd_stall, irq_defer, rd_valid, xm_stall}, 4'hD)
        end
        @(posedge clk);
        #1;
    endtask : xm

    // Result packs {fault, valid, data}
    task automatic cread(input logic [15:0] a, input logic f, output logic [9:0] c);
        @(posedge clk);
        rd_req <= 1'b1;
        rd_fetch <= f;
        rd_addr <= a;
        @(posedge clk);
        rd_req <= 1'b0;
        c[9] = rd_fault;
        #1;
        c[8:0] = {rd_valid, rd_rdata};
    endtask : cread

    initial begin
        logic [1:0] r;
        logic [31:0] d;
        logic [9:0] c;
        logic [15:0] a;
        logic [7:0] v1, v2;
        int n;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, xm_req, xm_we} = '0;
        {rd_req, rd_fetch, s_awaddr, s_araddr, s_wdata, xm_addr, xm_wdata, rd_addr} = '0;
        s_wstrb = 4'hF;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            axi_rd(4'(i * 4), d, r);
            `CHK({r, d}, {RESP_OKAY, (i == 1) ? (32'(BANK_RESET) << BANK_LSB) : 32'h0})
        end
        axi_rd(4'h6, d, r);
        `CHK(r, RESP_SLVERR)
        axi_wr(OFS_STATUS, 32'h1, r);
        axi_rd(OFS_STATUS, d, r);
        `CHK(d[0], 1'b0)
        rnd = lfsr(rnd);
        xm(1'b1, rnd[15:0], rnd[23:16], n);
        `CHK({n, external_data_ram_cnt, external_data_ram_last}, {32'h0, 32'h1, 1'b1, rnd[15:0], rnd[23:16]})
        a = 16'h0400 + {2'b00, rnd[13:0]};
        axi_wr(OFS_STORE_CTRL, 32'h1, r);
        xm(1'b1, a, 8'h00, n);
        `CHK({n, external_data_ram_cnt}, {32'h0, 32'h1})
        xm(1'b0, a, 8'h00, n);
        `CHK({external_data_ram_cnt, external_data_ram_last[24:8]}, {32'h2, 1'b0, a})
        cread(a, 1'b0, c);
        `CHK(c, {2'b01, ERASED_BYTE})
        axi_wr(OFS_SCALE, 32'h1, r);
        rnd = lfsr(rnd);
        v1 = rnd[7:0] & 8'h7F;
        v2 = rnd[15:8] & 8'hFE;
        xm(1'b1, a, v1, n);
        `CHK(n, 1 + WC)
        xm(1'b1, a, v2, n);
        cread(a, 1'b0, c);
        `CHK(c, {2'b01, prog_exp(v1, v2)})
        xm(1'b1, a + 16'h0400, v1, n);
        axi_rd(OFS_STORE_CTRL, d, r);
        `CHK(d[2:0], 3'b001)
        axi_wr(OFS_STORE_CTRL, 32'h3, r);
        xm(1'b1, a ^ 16'h0155, 8'h00, n);
        `CHK(n, EC)
        cread(a, 1'b0, c);
        `CHK(c, {2'b01, ERASED_BYTE})
        cread(a + 16'h0400, 1'b0, c);
        `CHK(c, {2'b01, v1})
        axi_wr(OFS_STORE_CTRL, 32'h1, r);
        // Upper window stays below the reserved top page of bank three
        for (int b = 1; b < 4; b++) begin
            axi_wr(OFS_BANK_SEL, 32'(b) << BANK_LSB, r);
            xm(1'b1, 16'h8000 | a, 8'h0F | (8'(b) << 4), n);
        end
        for (int b = 1; b < 4; b++) begin
            axi_wr(OFS_BANK_SEL, 32'(b) << BANK_LSB, r);
            cread(16'h8000 | a, 1'b0, c);
            `CHK(c, {2'b01, 8'h0F | (8'(b) << 4)})
        end
        cread(a + 16'h0400, 1'b0, c);
        `CHK(c, {2'b01, v1})
        axi_wr(OFS_BANK_SEL, 32'(BANK_RESET) << BANK_LSB, r);
        axi_wr(OFS_STORE_CTRL, 32'h5, r);
        xm(1'b1, 16'h0010, v1, n);
        xm(1'b1, 16'h0090, v2, n);
        cread(16'h0010, 1'b1, c);
        `CHK(c[9:8], 2'b10)
        cread(16'h0010, 1'b0, c);
        `CHK(c, {2'b01, v1})
        axi_wr(OFS_STORE_CTRL, 32'h1, r);
        cread(16'h0010, 1'b0, c);
        `CHK(c, {2'b01, ERASED_BYTE})
        axi_wr(OFS_STORE_CTRL, 32'h7, r);
        xm(1'b1, 16'h0020, 8'h00, n);
        cread(16'h0010, 1'b0, c);
        `CHK(c, {2'b01, ERASED_BYTE})
        cread(16'h0090, 1'b0, c);
        `CHK(c, {2'b01, v2})
        xm(1'b1, SCRATCH_BOTH, 8'h00, n);
        cread(16'h0090, 1'b0, c);
        `CHK(c, {2'b01, ERASED_BYTE})
        axi_wr(OFS_STORE_CTRL, 32'h0, r);
        axi_wr(OFS_SCALE, 32'h0, r);
        print_verdict();
    end
endmodule : tb_flash_program_erase_control
`default_nettype wire
